// ---- acs_pkg.sv ----
// Constants and types for the converter sequencer
package acs_pkg;
   // Register byte addresses
   localparam logic [4:0] ACS_CSA_ADDR  = 5'h00;
   localparam logic [4:0] ACS_CSB_ADDR  = 5'h04;
   localparam logic [4:0] ACS_CRR_ADDR  = 5'h08;
   localparam logic [4:0] ACS_RLO_ADDR  = 5'h0c;
   localparam logic [4:0] ACS_RHI_ADDR  = 5'h10;
   // Control status a fields
   localparam int ACS_EN_BIT    = 7;
   localparam int ACS_START_BIT = 6;
   localparam int ACS_AUTO_BIT  = 5;
   localparam int ACS_FLAG_BIT  = 4;
   localparam int ACS_DPS_LSB   = 0;
   // Control status b field
   localparam int ACS_TS_LSB    = 0;
   // Channel reference register fields
   localparam int ACS_REF_LSB   = 5;
   localparam int ACS_LAR_BIT   = 4;
   localparam int ACS_CH_LSB    = 0;
   // Reset values
   localparam logic [2:0] ACS_DPS_RST = 3'h0;
   localparam logic [2:0] ACS_TS_RST  = 3'h0;
   localparam logic [3:0] ACS_CH_RST  = 4'h0;
   localparam logic [2:0] ACS_REF_RST = 3'h0;
   // Trigger source that means free running
   localparam logic [2:0] ACS_TS_FREE = 3'h0;
   // Channel code of the temperature sensor
   localparam logic [3:0] ACS_CH_TEMP = 4'hf;
   // Timing in converter clock cycles, and the first trial bit mask
   localparam logic [4:0] ACS_FIRST_TOTAL  = 5'd25;
   localparam logic [4:0] ACS_NORM_TOTAL   = 5'd13;
   localparam logic [4:0] ACS_FIRST_SAMPLE = 5'd13;
   localparam logic [4:0] ACS_NORM_SAMPLE  = 5'd1;
   localparam logic [4:0] ACS_AUTO_SAMPLE  = 5'd2;
   localparam logic [9:0] ACS_MSB_MASK     = 10'h200;
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_PEND = 2'b01,
      ACS_CONV = 2'b10
   } acs_state_t;
endpackage

// ---- acs_sequencer.sv ----
// Successive-approximation converter sequencer with Avalon-MM registers
`timescale 1ns/1ps
module acs_sequencer (
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Trigger sources 1 to 7, asynchronous
   input  wire logic [6:0]  trigger_in,
   // Analog front end
   input  wire logic        comparator_in,
   output logic             power_out,
   output logic      [3:0]  input_channel_select_out,
   output logic      [2:0]  reference_select_out,
   output logic             gain_enable_out,
   output logic             gain_20x_out,
   output logic             temp_sensor_out,
   output logic             sample_hold_out,
   output logic      [9:0]  dac_trial_out
);
   import acs_pkg::*;

   typedef struct packed {
      logic        wait_req;
      logic [31:0] rdata;
      logic        en;
      logic        auto_trig;
      logic [2:0]  dps;
      logic [2:0]  ts;
      logic        flag;
      logic [3:0]  tmp_ch;
      logic [2:0]  tmp_ref;
      logic        lar;
      logic [3:0]  ch;
      logic [2:0]  refs;
      logic [6:0]  pre;
      acs_state_t  fsm;
      logic [4:0]  cnt;
      logic        first;
      logic        from_trig;
      logic [9:0]  sar;
      logic [9:0]  bitm;
      logic [9:0]  res;
      logic        lock;
      logic [6:0]  trig_s1;
      logic [6:0]  trig_s2;
      logic [6:0]  trig_d;
      logic        comp_s1;
      logic        comp_s2;
      logic        power;
      logic        gain_en;
      logic        gain20;
      logic        temp;
      logic        sample;
      logic [9:0]  dac;
   } acs_st_t;

   acs_st_t st;
   acs_st_t next_st;

   // Last prescaler count for a select value
   function automatic logic [6:0] acs_div_last(input logic [2:0] sel);
      logic [7:0] full;
      full = 8'h01 << sel;
      if (sel == 3'h0) begin
         acs_div_last = 7'h01;
      end else begin
         acs_div_last = 7'(full - 8'h01);
      end
   endfunction

   // Differential channel codes
   function automatic logic acs_is_diff(input logic [3:0] c);
      acs_is_diff = (c[3:2] == 2'b01) || (c[3:2] == 2'b10);
   endfunction

   logic       req;
   logic       cap;
   logic       acc_wr;
   logic       tick;
   logic       trig_lvl;
   logic       trig_edge;
   logic       trig_go;
   logic       done;
   logic       last_cyc;
   logic [4:0] total;
   logic [4:0] samp_at;
   logic [7:0] lo_byte;
   logic [7:0] hi_byte;
   logic       w_csa;
   logic       w_csb;
   logic       w_crr;

   always_comb begin
      next_st = st;
      req = avs_read_in | avs_write_in;
      cap = req & st.wait_req;
      acc_wr = avs_write_in & ~st.wait_req & avs_byteenable_in[0];
      w_csa = acc_wr && (avs_address_in == ACS_CSA_ADDR);
      w_csb = acc_wr && (avs_address_in == ACS_CSB_ADDR);
      w_crr = acc_wr && (avs_address_in == ACS_CRR_ADDR);

      // Prescaler tick, one cycle per converter clock
      tick = st.en && (st.pre == acs_div_last(st.dps));

      // Synchronised trigger level and its rising edge
      trig_lvl = 1'b0;
      trig_edge = 1'b0;
      if (st.ts != ACS_TS_FREE) begin
         trig_lvl = st.trig_s2[st.ts - 3'h1];
         trig_edge = trig_lvl & ~st.trig_d[st.ts - 3'h1];
      end
      // Busy edges fall outside idle and are lost
      trig_go = st.en && st.auto_trig && trig_edge
                && (st.fsm == ACS_IDLE);

      if (st.first) begin
         total = ACS_FIRST_TOTAL;
         samp_at = ACS_FIRST_SAMPLE;
      end else if (st.from_trig) begin
         total = ACS_NORM_TOTAL;
         samp_at = ACS_AUTO_SAMPLE;
      end else begin
         total = ACS_NORM_TOTAL;
         samp_at = ACS_NORM_SAMPLE;
      end
      last_cyc = (st.fsm == ACS_CONV) && (st.cnt == total - 5'd1);
      done = tick && last_cyc;

      // Result byte views
      if (st.lar) begin
         hi_byte = st.res[9:2];
         lo_byte = {st.res[1:0], 6'h00};
      end else begin
         hi_byte = {6'h00, st.res[9:8]};
         lo_byte = st.res[7:0];
      end

      // Bus handshake, one wait state on every access
      next_st.wait_req = ~cap;
      if (cap) begin
         next_st.rdata = 32'h0000_0000;
         if (avs_read_in) begin
            case (avs_address_in)
               ACS_CSA_ADDR: begin
                  next_st.rdata[ACS_EN_BIT] = st.en;
                  next_st.rdata[ACS_START_BIT] =
                     (st.fsm != ACS_IDLE);
                  next_st.rdata[ACS_AUTO_BIT] = st.auto_trig;
                  next_st.rdata[ACS_FLAG_BIT] = st.flag;
                  next_st.rdata[ACS_DPS_LSB +: 3] = st.dps;
               end
               ACS_CSB_ADDR: next_st.rdata[ACS_TS_LSB +: 3] = st.ts;
               ACS_CRR_ADDR: begin
                  next_st.rdata[ACS_REF_LSB +: 3] = st.tmp_ref;
                  next_st.rdata[ACS_LAR_BIT] = st.lar;
                  next_st.rdata[ACS_CH_LSB +: 4] = st.tmp_ch;
               end
               ACS_RLO_ADDR: begin
                  next_st.rdata[7:0] = lo_byte;
                  next_st.lock = 1'b1;
               end
               ACS_RHI_ADDR: begin
                  next_st.rdata[7:0] = hi_byte;
                  next_st.lock = 1'b0;
               end
               default: next_st.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Register writes
      if (w_csa) begin
         next_st.en = avs_writedata_in[ACS_EN_BIT];
         next_st.auto_trig = avs_writedata_in[ACS_AUTO_BIT];
         next_st.dps = avs_writedata_in[ACS_DPS_LSB +: 3];
      end
      if (w_csb) begin
         next_st.ts = avs_writedata_in[ACS_TS_LSB +: 3];
      end
      if (w_crr) begin
         next_st.tmp_ref = avs_writedata_in[ACS_REF_LSB +: 3];
         next_st.lar = avs_writedata_in[ACS_LAR_BIT];
         next_st.tmp_ch = avs_writedata_in[ACS_CH_LSB +: 4];
      end

      // Flag: write one clears, completion wins
      if (w_csa && avs_writedata_in[ACS_FLAG_BIT]) begin
         next_st.flag = 1'b0;
      end
      if (done) begin
         next_st.flag = 1'b1;
      end

      // Prescaler, held clear while disabled or on trigger
      if (!st.en || tick || trig_go) begin
         next_st.pre = 7'h00;
      end else begin
         next_st.pre = st.pre + 7'h01;
      end

      // Selections follow the temporary copy outside conversion
      if (st.fsm != ACS_CONV || (last_cyc && tick)) begin
         next_st.ch = st.tmp_ch;
         next_st.refs = st.tmp_ref;
      end

      // Sequencer
      next_st.sample = 1'b0;
      case (st.fsm)
         ACS_IDLE: begin
            if (w_csa && avs_writedata_in[ACS_START_BIT]
                && avs_writedata_in[ACS_EN_BIT]) begin
               next_st.fsm = ACS_PEND;
            end else if (trig_go) begin
               next_st.fsm = ACS_CONV;
               next_st.cnt = 5'd0;
               next_st.from_trig = 1'b1;
            end
         end
         ACS_PEND: begin
            if (tick) begin
               next_st.fsm = ACS_CONV;
               next_st.cnt = 5'd0;
               next_st.from_trig = 1'b0;
            end
         end
         ACS_CONV: begin
            if (tick) begin
               next_st.cnt = st.cnt + 5'd1;
               if (st.cnt == samp_at - 5'd1) begin
                  next_st.sample = 1'b1;
                  next_st.sar = ACS_MSB_MASK;
                  next_st.bitm = ACS_MSB_MASK;
               end else if (st.bitm != 10'h000) begin
                  // Keep the trial bit when input is above it
                  next_st.sar = (st.comp_s2
                                 ? st.sar : st.sar & ~st.bitm)
                                | (st.bitm >> 1);
                  next_st.bitm = st.bitm >> 1;
               end
            end
            if (done) begin
               next_st.first = 1'b0;
               if (!st.lock) begin
                  next_st.res = st.sar;
               end
               if (st.auto_trig && st.ts == ACS_TS_FREE) begin
                  next_st.fsm = ACS_CONV;
                  next_st.cnt = 5'd0;
                  next_st.from_trig = 1'b0;
               end else begin
                  next_st.fsm = ACS_IDLE;
               end
            end
         end
         default: next_st.fsm = ACS_IDLE;
      endcase

      // Disabling returns the sequencer to idle and re-arms the long first conversion
      // Enable and start may arrive in one write
      if (!next_st.en) begin
         next_st.fsm = ACS_IDLE;
         next_st.first = 1'b1;
         next_st.bitm = 10'h000;
      end

      // Synchronisers
      next_st.trig_s1 = trigger_in;
      next_st.trig_s2 = st.trig_s1;
      next_st.trig_d = st.trig_s2;
      next_st.comp_s1 = comparator_in;
      next_st.comp_s2 = st.comp_s1;

      // Analog controls, quiet while disabled except the DAC trial, which follows sar
      next_st.power = st.en;
      next_st.gain_en = st.en && acs_is_diff(st.ch);
      next_st.gain20 = st.en && acs_is_diff(st.ch)
                       && st.ch[0];
      next_st.temp = st.en && (st.ch == ACS_CH_TEMP);
      next_st.dac = st.sar;
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
         st.wait_req <= 1'b1;
         st.dps <= ACS_DPS_RST;
         st.ts <= ACS_TS_RST;
         st.tmp_ch <= ACS_CH_RST;
         st.ch <= ACS_CH_RST;
         st.tmp_ref <= ACS_REF_RST;
         st.refs <= ACS_REF_RST;
         st.fsm <= ACS_IDLE;
         st.first <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata_out = st.rdata;
   assign avs_waitrequest_out = st.wait_req;
   assign power_out = st.power;
   assign input_channel_select_out = st.ch;
   assign reference_select_out = st.refs;
   assign gain_enable_out = st.gain_en;
   assign gain_20x_out = st.gain20;
   assign temp_sensor_out = st.temp;
   assign sample_hold_out = st.sample;
   assign dac_trial_out = st.dac;

   a_pre_held_off: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !st.en |=> (st.pre == 7'h00))
      else $error("Prescaler ran while disabled");
   a_done_sets_flag: assert property (@(posedge core_clk_in)
      disable iff (rst_in) done |=> st.flag)
      else $error("Completion did not raise the flag");
   a_lock_keeps_res: assert property (@(posedge core_clk_in)
      disable iff (rst_in) (done && st.lock) |=> $stable(st.res))
      else $error("Locked result was overwritten");
   a_conv_not_retrig: assert property (@(posedge core_clk_in)
      disable iff (rst_in)
      (st.fsm == ACS_CONV && !done && !w_csa) |=> (st.fsm == ACS_CONV))
      else $error("Conversion broken off while busy");
   a_sel_locked: assert property (@(posedge core_clk_in)
      disable iff (rst_in)
      (st.fsm == ACS_CONV && !(last_cyc && tick)) |=> $stable(st.ch))
      else $error("Channel changed during conversion");
   a_pend_waits_tick: assert property (@(posedge core_clk_in)
      disable iff (rst_in)
      (st.fsm == ACS_PEND && !tick && !w_csa) |=> (st.fsm == ACS_PEND))
      else $error("Conversion began off the converter clock");
   a_bus_one_wait: assert property (@(posedge core_clk_in)
      disable iff (rst_in) (req && st.wait_req) |=> !st.wait_req)
      else $error("Bus access not answered");

   // Main scenarios reached
   c_first_done: cover property (@(posedge core_clk_in)
      disable iff (rst_in) done && st.first);
   c_lock_drop: cover property (@(posedge core_clk_in)
      disable iff (rst_in) done && st.lock);
   c_trig_start: cover property (@(posedge core_clk_in)
      disable iff (rst_in) trig_go);
   c_free_run: cover property (@(posedge core_clk_in)
      disable iff (rst_in) done && st.auto_trig && st.ts == ACS_TS_FREE);
endmodule

// ---- acs_afe_model.sv ----
// Analog front end model: comparator against a per-channel level
`timescale 1ns/1ps
module acs_afe_model (
   // Clock
   input  wire logic       core_clk_in,
   // From the sequencer
   input  wire logic       power_in,
   input  wire logic [3:0] channel_in,
   input  wire logic [9:0] trial_in,
   // To the sequencer
   output logic            comparator_out
);
   logic [9:0] level;
   logic       junk;
   // Unpowered comparator chatters so a stale level is never trusted
   initial junk = 1'b0;
   always @(posedge core_clk_in) begin
      junk <= ~junk;
   end
   assign level = {channel_in, channel_in, channel_in[1:0]};
   assign comparator_out = power_in ? (trial_in <= level) : junk;
endmodule

// ---- acs_sequencer_test.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module acs_sequencer_test;
   import acs_pkg::*;
   logic        clk;
   logic        rst;
   logic [4:0]  adr;
   logic        rd_s;
   logic        wr_s;
   logic [31:0] wd;
   logic [31:0] rdat;
   logic        wrq;
   logic [6:0]  trg;
   logic        cmp;
   logic        pwr;
   logic [3:0]  chs;
   logic        tmp;
   logic [9:0]  dac;
   logic [15:0] q[$];
   logic [15:0] ent;
   logic [7:0]  v;
   logic [3:0]  ch;
   logic [9:0]  r;
   int          n_errors;
   int          n_tests;
   int          k;
   int          t;

   acs_sequencer acs_sequencer_inst (
      .core_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
      .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wrq), .trigger_in(trg), .comparator_in(cmp),
      .power_out(pwr), .input_channel_select_out(chs),
      .reference_select_out(), .gain_enable_out(), .gain_20x_out(),
      .temp_sensor_out(tmp), .sample_hold_out(), .dac_trial_out(dac));
   acs_afe_model acs_afe_model_inst (.core_clk_in(clk), .power_in(pwr),
      .channel_in(chs), .trial_in(dac), .comparator_out(cmp));

   function automatic logic [9:0] tgt(input logic [3:0] c);
      return {c, c, c[1:0]};
   endfunction
   task automatic wrap_up;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic bad(input logic [7:0] e, input logic [7:0] g);
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
   endtask
   task automatic ck(input logic g, input logic e);
      n_tests++;
      if (g !== e) bad({7'h0, e}, {7'h0, g});
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wr_s <= w;
      rd_s <= !w;
      wd <= {24'h0, d};
      for (t = 0; t < 100; t++) begin
         @(posedge clk);
         if (wrq === 1'b0) break;
      end
      v = rdat[7:0];
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      if (t == 100) begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e,
                     input logic [7:0] m);
      q.push_back({m, e});
      bus(1'b0, a, 8'h00);
   endtask
   task automatic poll(input int b);
      int i;
      for (i = 0; i < 400; i++) begin
         rd(ACS_CSA_ADDR, 8'h00, 8'h00);
         if (v[b] === 1'b1) break;
      end
      if (i == 400) begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic res(input logic [3:0] c, input logic l);
      logic [9:0] x;
      x = tgt(c);
      rd(ACS_RLO_ADDR, l ? {x[1:0], 6'h0} : x[7:0], 8'hff);
      rd(ACS_RHI_ADDR, l ? x[9:2] : {6'h0, x[9:8]}, 8'hff);
   endtask

   // Watcher: each completed read is matched to the oldest note
   always @(posedge clk) begin
      if (rd_s && wrq === 1'b0 && q.size() > 0) begin
         ent = q.pop_front();
         if (ent[15:8] != 8'h00) begin
            n_tests++;
            if ((rdat[7:0] & ent[15:8]) !== (ent[7:0] & ent[15:8]))
               bad(ent[7:0], rdat[7:0]);
         end
      end
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      adr = 5'h00;
      rd_s = 1'b0;
      wr_s = 1'b0;
      wd = 32'h0;
      trg = 7'h00;
      n_errors = 0;
      n_tests = 0;
      k = $urandom(32'hb062);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(ACS_CSA_ADDR, 8'h00, 8'hff);
      rd(ACS_CSB_ADDR, 8'h00, 8'h07);
      rd(ACS_CRR_ADDR, 8'h00, 8'hff);
      bus(1'b0, 5'h14, 8'h00);
      ck(pwr, 1'b0);
      for (k = 0; k < 6; k++) begin
         ch = (k == 1) ? ACS_CH_TEMP : 4'($urandom);
         bus(1'b1, ACS_CRR_ADDR, {3'h0, k[0], ch});
         // Divide by four leaves room for the comparator synchroniser
         bus(1'b1, ACS_CSA_ADDR, 8'hd2);
         rd(ACS_CSA_ADDR, 8'hc0, 8'hc0);
         ck(tmp, ch == ACS_CH_TEMP);
         bus(1'b1, ACS_CRR_ADDR, {3'h0, k[0], ~ch});
         ck(chs === ch, 1'b1);
         poll(ACS_FLAG_BIT);
         rd(ACS_CSA_ADDR, 8'h90, 8'hd0);
         res(ch, k[0]);
      end
      // Low byte read locks out the next result
      r = tgt(4'h3);
      bus(1'b1, ACS_CRR_ADDR, 8'h03);
      bus(1'b1, ACS_CSA_ADDR, 8'hd2);
      poll(ACS_FLAG_BIT);
      rd(ACS_RLO_ADDR, r[7:0], 8'hff);
      bus(1'b1, ACS_CRR_ADDR, 8'h0c);
      bus(1'b1, ACS_CSA_ADDR, 8'hd2);
      poll(ACS_FLAG_BIT);
      rd(ACS_RHI_ADDR, {6'h0, r[9:8]}, 8'hff);
      bus(1'b1, ACS_CSA_ADDR, 8'hd2);
      poll(ACS_FLAG_BIT);
      res(4'hc, 1'b0);
      for (k = 1; k < 8; k++) begin
         bus(1'b1, ACS_CSB_ADDR, k[7:0]);
         bus(1'b1, ACS_CSA_ADDR, 8'hb2);
         trg <= 7'(1 << (k - 1));
         poll(ACS_START_BIT);
         trg <= 7'h00;
         @(posedge clk);
         trg <= 7'(1 << (k - 1));
         poll(ACS_FLAG_BIT);
         rd(ACS_CSA_ADDR, 8'h10, 8'h50);
         res(4'hc, 1'b0);
         trg <= 7'h00;
      end
      // Free running keeps converting
      bus(1'b1, ACS_CSB_ADDR, {5'h0, ACS_TS_FREE});
      bus(1'b1, ACS_CSA_ADDR, 8'hf2);
      poll(ACS_FLAG_BIT);
      rd(ACS_CSA_ADDR, 8'h50, 8'h50);
      bus(1'b1, ACS_CSA_ADDR, 8'hb2);
      poll(ACS_FLAG_BIT);
      rd(ACS_CSA_ADDR, 8'h50, 8'h50);
      bus(1'b1, ACS_CSA_ADDR, 8'h00);
      rd(ACS_CSA_ADDR, 8'h00, 8'h80);
      ck(pwr, 1'b0);
      wrap_up();
   end
endmodule
